/* pio_defs.svh */
// register offsets, reset values and rule summary for the port block
// assumes an 8-bit special-function register space driven by the cpu core
//
// What this block does
// - a write to a port data register is held in that port's latch, which drives the pins via the router.
// - a latch 0 drives the pin low, a latch 1 drives high if push-pull or floats if open-drain.
// - reading a port data register gives 0 for every pin set as an analog input.
// - reading a port data register gives the sampled pin level of each digital input.
// - an input-mode bit of 0 puts the pin in analog mode with pullup, driver and receiver off.
// - an output-mode bit of 0 makes the pin open-drain and 1 makes it push-pull. Port two keeps bits 7:1 at 0, so those pins stay open-drain.
// - the output-mode bit has no effect while the pin is in analog mode.
// - a bypass bit of 1 makes the router pass over that pin, 0 leaves it available.
// - a match event is raised while masked pin levels differ from the masked compare value.
// - a mask bit of 0 keeps its pin out of the match comparison.
// - each overdrive bit selects normal mode at 0 and high-impedance overdrive at 1.
// - read-modify-write reads of a port data register return the latch, not the pins.
// - a match event requests an interrupt when enabled and wakes the oscillator from suspend.
`ifndef PIO_DEFS_SVH
`define PIO_DEFS_SVH

`define PIO_P1_LATCH_ADDR 8'h90
`define PIO_P2_LATCH_ADDR 8'hA0
`define PIO_P1_OMODE_ADDR 8'hA5
`define PIO_P2_OMODE_ADDR 8'hA6
`define PIO_P0_OVDRV_ADDR 8'hB0
`define PIO_P1_MASK_ADDR 8'hBF
`define PIO_P1_VALUE_ADDR 8'hCF
`define PIO_P1_BYPASS_ADDR 8'hD5
`define PIO_P2_BYPASS_ADDR 8'hD6
`define PIO_P1_IMODE_ADDR 8'hF2
`define PIO_P2_IMODE_ADDR 8'hF3

`define PIO_LATCH_RST 8'hFF
`define PIO_OMODE_RST 8'h00
`define PIO_OVDRV_RST 8'h00
`define PIO_MASK_RST 8'h00
`define PIO_VALUE_RST 8'hFF
`define PIO_BYPASS_RST 8'h00
`define PIO_IMODE_RST 8'hFF
`define PIO_P2_OMODE_WMASK 8'h01
`define PIO_UNMAPPED_READ 8'h00

`endif

/* pio_pkg.sv */
// shared types for the port block
// assumes nothing beyond the defs header
package pio_pkg;

  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
  } pio_drv_t;

  typedef struct packed {
    logic [7:0] sel;
    logic [7:0] dat;
  } pio_xbar_t;

  typedef struct packed {
    logic [7:0] addr;
    logic wr;
    logic rd;
    logic rmw;
    logic [7:0] wdata;
  } pio_sfr_t;

endpackage

/* pio_port.sv */
// port one/two pin logic, match detector and port zero overdrive select
// assumes sfr requests and pin inputs are synchronous to clk
`timescale 1ns/1ns
`include "pio_defs.svh"

module pio_port (
  input wire logic clk,
  input wire logic rstn,
  input wire pio_pkg::pio_sfr_t sfr,
  output logic [7:0] sfr_rdata,
  input wire logic [7:0] p1_pin_in,
  input wire logic [7:0] p2_pin_in,
  input wire pio_pkg::pio_xbar_t p1_xbar,
  input wire pio_pkg::pio_xbar_t p2_xbar,
  output pio_pkg::pio_drv_t p1_drv,
  output pio_pkg::pio_drv_t p2_drv,
  output logic [7:0] p1_analog_en,
  output logic [7:0] p2_analog_en,
  output logic [7:0] p1_pullup_en,
  output logic [7:0] p2_pullup_en,
  output logic [7:0] p1_router_bypass,
  output logic [7:0] p2_router_bypass,
  output logic [7:0] p0_overdrive,
  input wire logic match_interrupt_enable,
  output logic match_evt,
  output logic match_irq,
  output logic osc_wake
);

  ////////////////////////////////////////////////////////////////
  // register state
  logic [7:0] p1_latch_r, p1_latch_nxt;
  logic [7:0] p2_latch_r, p2_latch_nxt;
  logic [7:0] p1_omode_r, p1_omode_nxt;
  logic [7:0] p2_omode_r, p2_omode_nxt;
  logic [7:0] p0_ovdrv_r, p0_ovdrv_nxt;
  logic [7:0] p1_mask_r, p1_mask_nxt;
  logic [7:0] p1_value_r, p1_value_nxt;
  logic [7:0] p1_bypass_r, p1_bypass_nxt;
  logic [7:0] p2_bypass_r, p2_bypass_nxt;
  logic [7:0] p1_imode_r, p1_imode_nxt;
  logic [7:0] p2_imode_r, p2_imode_nxt;
  logic [7:0] rdata_r, rdata_nxt;

  logic [7:0] p1_rd_pins;
  logic [7:0] p2_rd_pins;

  // analog pins read as zero
  assign p1_rd_pins = p1_pin_in & p1_imode_r;
  assign p2_rd_pins = p2_pin_in & p2_imode_r;

  always_comb begin
    p1_latch_nxt = p1_latch_r;
    p2_latch_nxt = p2_latch_r;
    p1_omode_nxt = p1_omode_r;
    p2_omode_nxt = p2_omode_r;
    p0_ovdrv_nxt = p0_ovdrv_r;
    p1_mask_nxt = p1_mask_r;
    p1_value_nxt = p1_value_r;
    p1_bypass_nxt = p1_bypass_r;
    p2_bypass_nxt = p2_bypass_r;
    p1_imode_nxt = p1_imode_r;
    p2_imode_nxt = p2_imode_r;
    if (sfr.wr) begin
      unique case (sfr.addr)
        `PIO_P1_LATCH_ADDR: p1_latch_nxt = sfr.wdata;
        `PIO_P2_LATCH_ADDR: p2_latch_nxt = sfr.wdata;
        `PIO_P1_OMODE_ADDR: p1_omode_nxt = sfr.wdata;
        `PIO_P2_OMODE_ADDR: p2_omode_nxt = sfr.wdata & `PIO_P2_OMODE_WMASK;
        `PIO_P0_OVDRV_ADDR: p0_ovdrv_nxt = sfr.wdata;
        `PIO_P1_MASK_ADDR: p1_mask_nxt = sfr.wdata;
        `PIO_P1_VALUE_ADDR: p1_value_nxt = sfr.wdata;
        `PIO_P1_BYPASS_ADDR: p1_bypass_nxt = sfr.wdata;
        `PIO_P2_BYPASS_ADDR: p2_bypass_nxt = sfr.wdata;
        `PIO_P1_IMODE_ADDR: p1_imode_nxt = sfr.wdata;
        `PIO_P2_IMODE_ADDR: p2_imode_nxt = sfr.wdata;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      p1_latch_r <= `PIO_LATCH_RST;
      p2_latch_r <= `PIO_LATCH_RST;
      p1_omode_r <= `PIO_OMODE_RST;
      p2_omode_r <= `PIO_OMODE_RST;
      p0_ovdrv_r <= `PIO_OVDRV_RST;
      p1_mask_r <= `PIO_MASK_RST;
      p1_value_r <= `PIO_VALUE_RST;
      p1_bypass_r <= `PIO_BYPASS_RST;
      p2_bypass_r <= `PIO_BYPASS_RST;
      p1_imode_r <= `PIO_IMODE_RST;
      p2_imode_r <= `PIO_IMODE_RST;
    end else begin
      p1_latch_r <= p1_latch_nxt;
      p2_latch_r <= p2_latch_nxt;
      p1_omode_r <= p1_omode_nxt;
      p2_omode_r <= p2_omode_nxt;
      p0_ovdrv_r <= p0_ovdrv_nxt;
      p1_mask_r <= p1_mask_nxt;
      p1_value_r <= p1_value_nxt;
      p1_bypass_r <= p1_bypass_nxt;
      p2_bypass_r <= p2_bypass_nxt;
      p1_imode_r <= p1_imode_nxt;
      p2_imode_r <= p2_imode_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////
  // read path
  always_comb begin
    rdata_nxt = rdata_r;
    if (sfr.rd) begin
      unique case (sfr.addr)
        `PIO_P1_LATCH_ADDR: rdata_nxt = sfr.rmw ? p1_latch_r : p1_rd_pins;
        `PIO_P2_LATCH_ADDR: rdata_nxt = sfr.rmw ? p2_latch_r : p2_rd_pins;
        `PIO_P1_OMODE_ADDR: rdata_nxt = p1_omode_r;
        `PIO_P2_OMODE_ADDR: rdata_nxt = p2_omode_r & `PIO_P2_OMODE_WMASK;
        `PIO_P0_OVDRV_ADDR: rdata_nxt = p0_ovdrv_r;
        `PIO_P1_MASK_ADDR: rdata_nxt = p1_mask_r;
        `PIO_P1_VALUE_ADDR: rdata_nxt = p1_value_r;
        `PIO_P1_BYPASS_ADDR: rdata_nxt = p1_bypass_r;
        `PIO_P2_BYPASS_ADDR: rdata_nxt = p2_bypass_r;
        `PIO_P1_IMODE_ADDR: rdata_nxt = p1_imode_r;
        `PIO_P2_IMODE_ADDR: rdata_nxt = p2_imode_r;
        default: rdata_nxt = `PIO_UNMAPPED_READ;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rdata_r <= 8'h00;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////
  // pin drivers
  function automatic pio_pkg::pio_drv_t pin_drive(
    input logic [7:0] dval,
    input logic [7:0] imode,
    input logic [7:0] omode
  );
    pio_pkg::pio_drv_t d;
    d.out = dval & imode;
    // low always driven, high only when push-pull, analog never
    d.oe = imode & (~dval | omode);
    return d;
  endfunction

  logic [7:0] p1_dval, p2_dval;
  pio_pkg::pio_drv_t p1_drv_r, p1_drv_nxt;
  pio_pkg::pio_drv_t p2_drv_r, p2_drv_nxt;
  logic [7:0] p1_an_r, p1_an_nxt, p2_an_r, p2_an_nxt;
  logic [7:0] p1_pu_r, p1_pu_nxt, p2_pu_r, p2_pu_nxt;

  always_comb begin
    // router data takes the pin where selected, else the latch
    p1_dval = (p1_xbar.sel & p1_xbar.dat) | (~p1_xbar.sel & p1_latch_r);
    p2_dval = (p2_xbar.sel & p2_xbar.dat) | (~p2_xbar.sel & p2_latch_r);
    p1_drv_nxt = pin_drive(p1_dval, p1_imode_r, p1_omode_r);
    p2_drv_nxt = pin_drive(p2_dval, p2_imode_r, p2_omode_r);
    p1_an_nxt = ~p1_imode_r;
    p2_an_nxt = ~p2_imode_r;
    p1_pu_nxt = p1_imode_r;
    p2_pu_nxt = p2_imode_r;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      p1_drv_r <= '0;
      p2_drv_r <= '0;
      p1_an_r <= 8'h00;
      p2_an_r <= 8'h00;
      p1_pu_r <= 8'h00;
      p2_pu_r <= 8'h00;
    end else begin
      p1_drv_r <= p1_drv_nxt;
      p2_drv_r <= p2_drv_nxt;
      p1_an_r <= p1_an_nxt;
      p2_an_r <= p2_an_nxt;
      p1_pu_r <= p1_pu_nxt;
      p2_pu_r <= p2_pu_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////
  // match detector
  logic match_nxt, irq_nxt;
  logic match_r, irq_r, wake_r;

  always_comb begin
    match_nxt = (p1_rd_pins & p1_mask_r) != (p1_value_r & p1_mask_r);
    irq_nxt = match_nxt & match_interrupt_enable;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      match_r <= 1'b0;
      irq_r <= 1'b0;
      wake_r <= 1'b0;
    end else begin
      match_r <= match_nxt;
      irq_r <= irq_nxt;
      wake_r <= match_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////
  // outputs
  assign sfr_rdata = rdata_r;
  assign p1_drv = p1_drv_r;
  assign p2_drv = p2_drv_r;
  assign p1_analog_en = p1_an_r;
  assign p2_analog_en = p2_an_r;
  assign p1_pullup_en = p1_pu_r;
  assign p2_pullup_en = p2_pu_r;
  assign p1_router_bypass = p1_bypass_r;
  assign p2_router_bypass = p2_bypass_r;
  assign p0_overdrive = p0_ovdrv_r;
  assign match_evt = match_r;
  assign match_irq = irq_r;
  assign osc_wake = wake_r;

  ////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  latch_write_a: assert property (
    sfr.wr && sfr.addr == `PIO_P1_LATCH_ADDR |=> p1_latch_r == $past(sfr.wdata)
  ) else $error("port one latch missed a write");

  low_drive_a: assert property (
    p1_imode_r[0] && !p1_dval[0] |=> p1_drv.oe[0] && !p1_drv.out[0]
  ) else $error("latch zero did not drive low");

  open_drain_a: assert property (
    p1_imode_r[0] && p1_dval[0] && !p1_omode_r[0] |=> !p1_drv.oe[0]
  ) else $error("open-drain high was driven");

  push_pull_a: assert property (
    p2_imode_r[0] && p2_dval[0] && p2_omode_r[0] |=> p2_drv.oe[0] && p2_drv.out[0]
  ) else $error("push-pull high not driven");

  analog_off_a: assert property (
    !p1_imode_r[3] |=> !p1_drv.oe[3] && p1_analog_en[3] && !p1_pullup_en[3]
  ) else $error("analog pin still driven");

  analog_read_a: assert property (
    sfr.rd && !sfr.rmw && sfr.addr == `PIO_P2_LATCH_ADDR
    |=> (sfr_rdata & ~$past(p2_imode_r)) == 8'h00
  ) else $error("analog pin read nonzero");

  pin_read_a: assert property (
    sfr.rd && !sfr.rmw && sfr.addr == `PIO_P1_LATCH_ADDR
    |=> sfr_rdata == $past(p1_pin_in & p1_imode_r)
  ) else $error("pin read wrong");

  rmw_read_a: assert property (
    sfr.rd && sfr.rmw && sfr.addr == `PIO_P1_LATCH_ADDR |=> sfr_rdata == $past(p1_latch_r)
  ) else $error("rmw read did not return latch");

  match_event_a: assert property (
    ((p1_rd_pins ^ p1_value_r) & p1_mask_r) != 8'h00 |=> match_evt && osc_wake
  ) else $error("match event missed");

  mask_exclude_a: assert property (
    p1_mask_r == 8'h00 |=> !match_evt
  ) else $error("masked pins raised match");

  irq_gate_a: assert property (
    match_evt && !$past(match_interrupt_enable) |-> !match_irq
  ) else $error("irq raised while disabled");

  omode_upper_a: assert property (
    sfr.wr && sfr.addr == `PIO_P2_OMODE_ADDR |=> p2_omode_r[7:1] == 7'h00
  ) else $error("upper output-mode bits written");

  ovdrv_a: assert property (
    sfr.wr && sfr.addr == `PIO_P0_OVDRV_ADDR |=> p0_overdrive == $past(sfr.wdata)
  ) else $error("overdrive select not applied");

  rmw_read_two_a: assert property (
    sfr.rd && sfr.rmw && sfr.addr == `PIO_P2_LATCH_ADDR |=> sfr_rdata == $past(p2_latch_r)
  ) else $error("port two rmw read did not return latch");

  irq_enable_a: assert property (
    match_evt && $past(match_interrupt_enable) |-> match_irq
  ) else $error("irq missing while enabled");

  bypass_write_a: assert property (
    sfr.wr && sfr.addr == `PIO_P2_BYPASS_ADDR |=> p2_router_bypass == $past(sfr.wdata)
  ) else $error("port two bypass missed a write");

  analog_two_a: assert property (
    !p2_imode_r[0] |=> p2_analog_en[0] && !p2_pullup_en[0] && !p2_drv.oe[0]
  ) else $error("port two analog pin still active");

  match_clear_a: assert property (
    ((p1_rd_pins ^ p1_value_r) & p1_mask_r) == 8'h00 |=> !match_evt && !osc_wake
  ) else $error("match event without mismatch");

endmodule

/* pio_pins_model.sv */
// pin and board model for one port of the port block
// assumes drive and pullup outputs of the port block; board drive set by the bench
`timescale 1ns/1ns
module pio_pins_model (
  input wire logic clk,
  input wire pio_pkg::pio_drv_t drv,
  input wire logic [7:0] pullup_en,
  input wire logic [7:0] ext_en,
  input wire logic [7:0] ext_val,
  output logic [7:0] pin_in
);
  logic wig_r;
  initial wig_r = 1'b0;
  always @(posedge clk) wig_r <= ~wig_r;
  // device driver, then board driver, then pullup, else a wandering level
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (drv.oe[i]) pin_in[i] = drv.out[i];
      else if (ext_en[i]) pin_in[i] = ext_val[i];
      else if (pullup_en[i]) pin_in[i] = 1'b1;
      else pin_in[i] = wig_r ^ i[0];
    end
  end
endmodule

/* test_port_io_config_match.sv */
// self-checking bench for the port block
// assumes pio_port with two pin models on ports one and two
`timescale 1ns/1ns
module test_port_io_config_match;
  logic clk, rstn, mie, evt, irq, wake;
  pio_pkg::pio_sfr_t sfr;
  pio_pkg::pio_xbar_t x1, x2;
  pio_pkg::pio_drv_t d1, d2;
  logic [7:0] rdata, an1, an2, pu1, pu2, byp1, byp2, ovd, e1, v1, e2, v2, pin1, pin2;
  int errors = 0;
  int samples_checked = 0;
  int cyc = 0;
  localparam logic [7:0] RA [12] = '{8'h90, 8'hA0, 8'hA5, 8'hA6, 8'hB0, 8'hBF, 8'hCF, 8'hD5, 8'hD6,
    8'hF2, 8'hF3, 8'h91};
  localparam logic [7:0] RV [12] = '{8'hFF, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00, 8'hFF, 8'h00, 8'h00,
    8'hFF, 8'hFF, 8'h00};
  pio_port uut (.clk(clk), .rstn(rstn), .sfr(sfr), .sfr_rdata(rdata), .p1_pin_in(pin1), .p2_pin_in(pin2),
    .p1_xbar(x1), .p2_xbar(x2), .p1_drv(d1), .p2_drv(d2), .p1_analog_en(an1), .p2_analog_en(an2),
    .p1_pullup_en(pu1), .p2_pullup_en(pu2), .p1_router_bypass(byp1), .p2_router_bypass(byp2),
    .p0_overdrive(ovd), .match_interrupt_enable(mie), .match_evt(evt), .match_irq(irq), .osc_wake(wake));
  pio_pins_model m1 (.clk(clk), .drv(d1), .pullup_en(pu1), .ext_en(e1), .ext_val(v1), .pin_in(pin1));
  pio_pins_model m2 (.clk(clk), .drv(d2), .pullup_en(pu2), .ext_en(e2), .ext_val(v2), .pin_in(pin2));
  ////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      errors++;
      close_out();
    end
  end
  ////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    sfr.addr = a;
    sfr.wdata = d;
    sfr.wr = 1'b1;
    @(negedge clk);
    sfr.wr = 1'b0;
  endtask
  task automatic rc(input logic [7:0] a, input logic m, input logic [7:0] exp, input string what);
    @(negedge clk);
    sfr.addr = a;
    sfr.rmw = m;
    sfr.rd = 1'b1;
    @(negedge clk);
    sfr.rd = 1'b0;
    sfr.rmw = 1'b0;
    chk(rdata, exp, what);
  endtask
  task automatic wt();
    repeat (2) @(negedge clk);
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic t_reset();
    for (int i = 0; i < 12; i++) rc(RA[i], 1'b0, RV[i], "reset value");
    chk(d1.oe, 8'h00, "reset oe");
    chk(pu1, 8'hFF, "reset pullup");
    chk(an1, 8'h00, "reset analog");
    chk({7'h00, evt}, 8'h00, "reset match");
    $display("test reset done");
  endtask
  task automatic t_latch();
    wr(8'h90, 8'h5A);
    wr(8'hA5, 8'h0F);
    e1 = 8'h50;
    v1 = 8'h00;
    wt();
    chk(d1.out, 8'h5A, "drive level");
    chk(d1.oe, 8'hAF, "drive enable");
    rc(8'h90, 1'b0, 8'h0A, "pin read");
    rc(8'h90, 1'b1, 8'h5A, "latch read");
    e1 = 8'h00;
    $display("test latch done");
  endtask
  task automatic t_analog();
    wr(8'hA0, 8'hF1);
    wr(8'hA6, 8'hFF);
    wr(8'hF3, 8'h0E);
    wr(8'hD6, 8'hF1);
    wt();
    chk(an2, 8'hF1, "analog");
    chk(pu2, 8'h0E, "pullup");
    chk(d2.oe, 8'h0E, "analog oe");
    chk(d2.out, 8'h00, "analog out");
    chk(byp2, 8'hF1, "bypass two");
    rc(8'hA0, 1'b0, 8'h00, "analog read");
    rc(8'hA0, 1'b1, 8'hF1, "latch read two");
    rc(8'hA6, 1'b0, 8'h01, "omode two");
    wr(8'hF3, 8'h0F);
    wt();
    chk(d2.oe, 8'h0F, "push-pull oe");
    chk(d2.out, 8'h01, "push-pull out");
    x2.sel = 8'h01;
    x2.dat = 8'h00;
    wt();
    chk(d2.out, 8'h00, "routed low");
    chk(d2.oe, 8'h0F, "routed low oe");
    x2 = '0;
    $display("test analog done");
  endtask
  task automatic t_router();
    x1.sel = 8'h01;
    x1.dat = 8'h01;
    wr(8'hD5, 8'h3C);
    wr(8'hB0, 8'hA5);
    wt();
    chk(d1.out, 8'h5B, "routed out");
    chk(byp1, 8'h3C, "bypass one");
    chk(ovd, 8'hA5, "overdrive");
    rc(8'hB0, 1'b0, 8'hA5, "overdrive read");
    wr(8'hF2, 8'hF7);
    wt();
    chk(an1, 8'h08, "analog one");
    chk(pu1, 8'hF7, "pullup one");
    chk(d1.oe, 8'hA7, "analog one oe");
    rc(8'h90, 1'b0, 8'h53, "analog one read");
    wr(8'hF2, 8'hFF);
    x1 = '0;
    $display("test router done");
  endtask
  task automatic t_match();
    wr(8'h90, 8'hFF);
    wr(8'hA5, 8'h00);
    wr(8'hCF, 8'h0F);
    e1 = 8'hFF;
    v1 = 8'h00;
    wt();
    chk({7'h00, evt}, 8'h00, "masked off");
    wr(8'hBF, 8'h0F);
    wt();
    chk({5'h00, evt, wake, irq}, 8'h06, "mismatch");
    mie = 1'b1;
    wt();
    chk({7'h00, irq}, 8'h01, "irq on");
    v1 = 8'h0F;
    wt();
    chk({5'h00, evt, wake, irq}, 8'h00, "equal");
    v1 = 8'h3F;
    wt();
    chk({7'h00, evt}, 8'h00, "unmasked change");
    $display("test match done");
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    rstn = 1'b0;
    sfr = '0;
    x1 = '0;
    x2 = '0;
    mie = 1'b0;
    e1 = 8'h00;
    v1 = 8'h00;
    e2 = 8'h00;
    v2 = 8'h00;
    repeat (4) @(negedge clk);
    rstn = 1'b1;
    t_reset();
    t_latch();
    t_analog();
    t_router();
    t_match();
    close_out();
  end
endmodule
